//--- hdl/trbl_consts.vh
`ifndef TRBL_CONSTS_VH
`define TRBL_CONSTS_VH
`define TRBL_PTR_LOCAL_HI   8'h00
`define TRBL_PTR_REMOTE_HI  8'h01
`define TRBL_PTR_FLAGS      8'h02
`define TRBL_PTR_REMOTE_LO  8'h10
`define TRBL_PTR_LOCAL_LO   8'h15
`define TRBL_PTR_RESET      8'h00
`define TRBL_BYTE_RESET     8'h00
`define TRBL_RES_HI_MSB     11
`define TRBL_RES_HI_LSB     4
`define TRBL_RES_LO_MSB     3
`define TRBL_NUM_CH         2
`define TRBL_CH_LOCAL       0
`define TRBL_CH_REMOTE      1
`endif

//--- hdl/trbl_chan.v
`timescale 1ns/10ps
`include "trbl_consts.vh"
// one channel's high/low result pair with the coherency lock
module trbl_chan
(
  input  wire        clock,
  input  wire        rstn,
  input  wire        done,
  input  wire [11:0] result,
  input  wire        rd_hi,
  input  wire        rd_lo,
  input  wire        rd_other,
  output reg  [7:0]  hi_byte,
  output reg  [7:0]  lo_byte,
  output reg         hi_held,
  output reg         lo_held
);

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      hi_byte <= `TRBL_BYTE_RESET;
      lo_byte <= `TRBL_BYTE_RESET;
      hi_held <= 1'b0;
      lo_held <= 1'b0;
    end
    else
    begin
      // a held byte skips this conversion's load; a read in the same cycle already
      // blocks its partner, or the pair would straddle two conversions
      if (done && !hi_held && !rd_lo)
        hi_byte <= result[`TRBL_RES_HI_MSB:`TRBL_RES_HI_LSB];
      if (done && !lo_held && !rd_hi)
        lo_byte <= {result[`TRBL_RES_LO_MSB:0], 4'h0};
      // a read that completes a pair releases it, any other read of the pair starts a hold, a read elsewhere releases both
      if (rd_hi)
      begin
        hi_held <= 1'b0;
        lo_held <= !hi_held;
      end
      else if (rd_lo)
      begin
        lo_held <= 1'b0;
        hi_held <= !lo_held;
      end
      else if (rd_other)
      begin
        hi_held <= 1'b0;
        lo_held <= 1'b0;
      end
    end
  end

endmodule

//--- hdl/trbl_top.v
`timescale 1ns/10ps
`include "trbl_consts.vh"
// Overview of operation
// - local whole degrees at 00h, read-only
// - remote whole degrees at 01h, read-only
// - conversion end loads bytes unless held or partner read that cycle
// - high read first holds low until read
// - low read first holds high
// - other register read ends pairing hold
// - status byte at 02h, read-only
// - fractions in upper nibble, 15h/10h
// - every write command loads the pointer
module trbl_top
(
  input  wire        clock,
  input  wire        rstn,
  input  wire        wr_cmd,
  input  wire [7:0]  wr_ptr,
  input  wire        rd_cmd,
  input  wire        local_done,
  input  wire [11:0] local_result,
  input  wire        remote_done,
  input  wire [11:0] remote_result,
  input  wire [7:0]  flags_in,
  output reg  [7:0]  rd_data,
  output reg         rd_valid,
  output reg  [7:0]  pointer,
  output reg  [7:0]  local_result_upper_bits,
  output reg  [7:0]  remote_result_upper_bits,
  output reg  [3:0]  held
);

  wire [7:0] hi_b [0:1];
  wire [7:0] lo_b [0:1];
  wire [1:0] hi_h;
  wire [1:0] lo_h;
  reg  [7:0] next_rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // pointer of a channel's whole-degree byte
  function [7:0] hi_ptr;
    input integer ch;
    begin
      if (ch == `TRBL_CH_LOCAL)
        hi_ptr = `TRBL_PTR_LOCAL_HI;
      else
        hi_ptr = `TRBL_PTR_REMOTE_HI;
    end
  endfunction

  // pointer of a channel's fraction byte
  function [7:0] lo_ptr;
    input integer ch;
    begin
      if (ch == `TRBL_CH_LOCAL)
        lo_ptr = `TRBL_PTR_LOCAL_LO;
      else
        lo_ptr = `TRBL_PTR_REMOTE_LO;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // a read of any pointer outside a channel's pair ends that channel's hold
  genvar ch;
  generate
    for (ch = 0; ch < `TRBL_NUM_CH; ch = ch + 1)
    begin : g_chan
      wire rd_hi = rd_cmd && (pointer == hi_ptr(ch));
      wire rd_lo = rd_cmd && (pointer == lo_ptr(ch));
      trbl_chan u_chan
      (
        .clock    (clock),
        .rstn     (rstn),
        .done     ((ch == `TRBL_CH_LOCAL) ? local_done : remote_done),
        .result   ((ch == `TRBL_CH_LOCAL) ? local_result : remote_result),
        .rd_hi    (rd_hi),
        .rd_lo    (rd_lo),
        .rd_other (rd_cmd && !rd_hi && !rd_lo),
        .hi_byte  (hi_b[ch]),
        .lo_byte  (lo_b[ch]),
        .hi_held  (hi_h[ch]),
        .lo_held  (lo_h[ch])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // unmapped pointers read as zero; writes to result pointers only move the pointer
  always @*
  begin
    case (pointer)
      `TRBL_PTR_LOCAL_HI:  next_rd_data = hi_b[0];
      `TRBL_PTR_REMOTE_HI: next_rd_data = hi_b[1];
      `TRBL_PTR_FLAGS:     next_rd_data = flags_in;
      `TRBL_PTR_REMOTE_LO: next_rd_data = lo_b[1];
      `TRBL_PTR_LOCAL_LO:  next_rd_data = lo_b[0];
      default:             next_rd_data = 8'h00;
    endcase
  end

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      pointer                  <= `TRBL_PTR_RESET;
      rd_data                  <= 8'h00;
      rd_valid                 <= 1'b0;
      local_result_upper_bits  <= `TRBL_BYTE_RESET;
      remote_result_upper_bits <= `TRBL_BYTE_RESET;
      held                     <= 4'h0;
    end
    else
    begin
      if (wr_cmd)
        pointer <= wr_ptr;
      rd_valid <= rd_cmd;
      if (rd_cmd)
        rd_data <= next_rd_data;
      local_result_upper_bits  <= hi_b[0];
      remote_result_upper_bits <= hi_b[1];
      held <= {hi_h[1], lo_h[1], hi_h[0], lo_h[0]};
    end
  end

endmodule

//--- tb/trbl_host.sv
`timescale 1ns/10ps
module trbl_host
(
  input  logic       clock,
  input  logic [7:0] rd_data,
  output logic       wr_cmd = 1'b0,
  output logic       rd_cmd = 1'b0,
  output logic [7:0] wr_ptr = 8'h00
);
  logic [7:0] q;
  // data is taken a half cycle after it lands, clear of the edge
  task rd(input logic [7:0] p);
    @(posedge clock) {wr_cmd, wr_ptr} <= {1'b1, p};
    @(posedge clock) {wr_cmd, rd_cmd} <= 2'b01;
    @(posedge clock) rd_cmd <= 1'b0;
    @(negedge clock) q = rd_data;
  endtask
endmodule

//--- tb/trbl_sva.sv
`timescale 1ns/10ps
module trbl_sva
(
  input logic       clock, rstn, wr_cmd, rd_cmd, rd_valid,
  input logic [7:0] wr_ptr, rd_data, pointer,
  input logic [3:0] held
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  ptr_load_a: assert property (wr_cmd |=> pointer == $past(wr_ptr)) else $error("ptr");
  ptr_keep_a: assert property (!wr_cmd |=> $stable(pointer)) else $error("ptr");
  rd_ans_a: assert property (rd_cmd |=> rd_valid) else $error("rd");
  rd_idle_a: assert property (!rd_cmd |=> !rd_valid && $stable(rd_data)) else $error("rd");
  rd_gap_a: assert property (rd_cmd && pointer == 8'h03 |=> rd_data == 8'h00)
    else $error("gap");
  lo_lock_a: assert property (rd_cmd && !$past(rd_cmd) && pointer == 8'h00 && held == 4'h0
    |-> ##2 held[0]) else $error("lock");
  hi_lock_a: assert property (rd_cmd && !$past(rd_cmd) && pointer == 8'h10 && held == 4'h0
    |-> ##2 held[3]) else $error("lock");
  unlock_a: assert property (rd_cmd && pointer == 8'h02 |-> ##2 held == 4'h0)
    else $error("lock");
endmodule

//--- tb/temp_result_byte_lock_tb_top.sv
`timescale 1ns/10ps
module temp_result_byte_lock_tb_top;
  logic        clock = 0, rstn = 0, local_done = 0, remote_done = 0;
  logic [11:0] local_result = 0, remote_result = 0;
  logic [7:0]  flags_in = 8'ha5;
  wire  [7:0]  rd_data, wr_ptr, pointer, local_result_upper_bits, remote_result_upper_bits;
  wire  [3:0]  held;
  wire         wr_cmd, rd_cmd, rd_valid;
  int          errors = 0, checks = 0;
  trbl_top  uut (.*);
  trbl_host h (.*);
  initial forever #5 clock = ~clock;
  task rc(input logic [7:0] p, e);
    h.rd(p);
    checks++;
    errors += (h.q !== e);
    if (h.q !== e)
      $display("mismatch ptr %h exp %h got %h", p, e, h.q);
  endtask
  task cu(input logic [7:0] el, er);
    checks += 2;
    errors += (local_result_upper_bits !== el) + (remote_result_upper_bits !== er);
    if (local_result_upper_bits !== el || remote_result_upper_bits !== er)
      $display("mismatch upper_bits exp %h %h got %h %h", el, er,
               local_result_upper_bits, remote_result_upper_bits);
  endtask
  task cv(input logic [23:0] v);
    @(posedge clock) {local_done, remote_done, local_result, remote_result} <= {2'b11, v};
    @(posedge clock) {local_done, remote_done} <= 2'b00;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rc(8'h00, 8'h00);
    cv(24'h1a52c3);
    rc(8'h00, 8'h1a);
    cv(24'h3b74d9);
    rc(8'h15, 8'h00);
    rc(8'h10, 8'h90);
    cv(24'h5e16f2);
    rc(8'h01, 8'h4d);
    cu(8'h5e, 8'h4d);
    rc(8'h00, 8'h5e);
    rc(8'h02, 8'ha5);
    cv(24'h7c3000);
    rc(8'h15, 8'h30);
    cu(8'h7c, 8'h00);
    rc(8'h03, 8'h00);
    $display("test done");
    give_verdict;
  end
  initial
  begin
    #5000 errors++;
    give_verdict;
  end
endmodule
bind trbl_top trbl_sva chk (.*);
